// File: src/id_page_pkg.sv
package id_page_pkg;
  // Core clock and internally timed write cycle
  localparam int CLK_PERIOD_NS = 10;
  localparam int INTERNAL_WRITE_TIME_NS = 4000000;
  localparam int WRITE_CYCLES_DEF = INTERNAL_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 20;

  // Instruction codes, compared after masking the don't-care bit 3
  localparam logic [7:0] OPCODE_MASK = 8'hf7;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] ID_PAGE_WRITE_CMD = 8'h82;
  localparam logic [7:0] ID_PAGE_READ_CMD = 8'h83;

  // Address and data field positions
  localparam int ADDR_SELECT_BIT = 7;
  localparam int LOCK_DATA_BIT = 1;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 4'hf;

  // Page and error-correction layout
  localparam int PAGE_BYTES = 16;
  localparam int GROUPS = 4;
  localparam int GROUP_W = 32;
  localparam int CHECK_W = 6;
  localparam int CODE_W = 38;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [6:0] LOCK_STATUS_PAD = 7'h00;
  localparam logic [1:0] BP_ALL = 2'h3;

  // Instruction decoding phases
  typedef enum logic [3:0] {
    PH_IDLE, PH_OPCODE, PH_WRITE_ENABLE_CMD, PH_ADDR_WR, PH_ADDR_RD,
    PH_WDATA, PH_LOCKDATA, PH_RDPAGE, PH_RDLOCK, PH_IGNORE
  } phase_t;
endpackage : id_page_pkg

// File: src/byte_buffer2.sv
module byte_buffer2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rdPtr;
    logic wrPtr;
    logic [1:0] count;
  } buf_t;

  buf_t q;
  buf_t d;
  logic push;
  logic pop;

  // Honest flags straight from the occupancy count
  assign inReady = q.count != 2'h2;
  assign outValid = q.count != 2'h0;
  assign outData = q.mem[q.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Pointer and count update; clear drops both entries at once
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wrPtr] = inData;
      d.wrPtr = !q.wrPtr;
    end
    if (pop) begin
      d.rdPtr = !q.rdPtr;
    end
    d.count = q.count + {1'b0, push} - {1'b0, pop};
    if (clear) begin
      d.rdPtr = 1'b0;
      d.wrPtr = 1'b0;
      d.count = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : byte_buffer2

// File: src/id_page_access.sv
module id_page_access #(
  parameter int WRITE_CYCLES = id_page_pkg::WRITE_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link pins
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic soEn,
  // Status register bits
  input wire logic blockProtectHi,
  input wire logic blockProtectLo,
  output logic writeEnableLatch,
  output logic writeBusy,
  output logic pageLocked
);
  import id_page_pkg::*;

  typedef struct packed {
    logic csMeta, csSync, csPrev;
    logic sckMeta, sckSync, sckPrev;
    logic siMeta, siSync;
    phase_t phase;
    logic [2:0] bitCnt;
    logic [7:0] inShift;
    logic [ADDR_W-1:0] addr;
    logic [PAGE_BYTES*8-1:0] stage;
    logic [GROUPS-1:0] dirty;
    logic armed, rdDone, gotData, lockReq, write_enable_latch, busy, kindLock;
    logic [CNT_W-1:0] busyCnt;
    logic [7:0] outShift;
    logic [2:0] outCnt;
    logic so, soEn;
  } state_t;
  state_t q;
  state_t d;
  logic [PAGE_BYTES*8-1:0] corrPage;
  logic csRise, csFall, sckRise, sckFall, readPhase, byteDone;
  logic commit, startWrite, startLock;
  logic [7:0] newByte;
  logic bufInValid, bufInReady, bufOutValid, bufOutReady, bufPush;
  logic [7:0] bufInData, bufOutData;

  // Hamming code over one group; data fills the non-power-of-two slots
  function automatic logic [CODE_W-1:0] eccEncode(
      input logic [GROUP_W-1:0] data);
    logic [CODE_W-1:0] code;
    int j;
    code = '0;
    j = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        code[p-1] = data[j];
        j++;
      end
    end
    for (int k = 0; k < CHECK_W; k++) begin
      for (int p = 1; p <= CODE_W; p++) begin
        if (((p >> k) & 1) == 1 && p != (1 << k)) begin
          code[(1 << k) - 1] = code[(1 << k) - 1] ^ code[p-1];
        end
      end
    end
    return code;
  endfunction : eccEncode
  // Syndrome points at the single flipped position, if any
  function automatic logic [GROUP_W-1:0] eccCorrect(
      input logic [CODE_W-1:0] code);
    logic [CHECK_W-1:0] syn;
    logic [GROUP_W-1:0] data;
    int j;
    syn = '0;
    data = '0;
    j = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if (code[p-1]) begin
        syn = syn ^ CHECK_W'(p);
      end
    end
    if (syn != '0 && int'(syn) <= CODE_W) begin
      code[int'(syn) - 1] = !code[int'(syn) - 1];
    end
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        data[j] = code[p-1];
        j++;
      end
    end
    return data;
  endfunction : eccCorrect
  // Nonvolatile cells ignore reset; the page is delivered erased
  localparam logic [CODE_W-1:0] ERASED_CODE = eccEncode({4{ERASED_BYTE}});
  logic [CODE_W-1:0] pageMem [GROUPS] = '{default: ERASED_CODE};
  logic lockedNv = 1'b0;
  // Corrected view of the page, group by group
  always_comb begin
    for (int g = 0; g < GROUPS; g++) begin
      corrPage[g*GROUP_W +: GROUP_W] = eccCorrect(pageMem[g]);
    end
  end
  // Edges seen only on the second synchroniser stage
  assign csRise = q.csSync && !q.csPrev;
  assign csFall = !q.csSync && q.csPrev;
  assign sckRise = q.sckSync && !q.sckPrev;
  assign sckFall = !q.sckSync && q.sckPrev;
  assign byteDone = sckRise && q.bitCnt == 3'h7;
  assign newByte = {q.inShift[6:0], q.siSync};
  assign readPhase = q.phase == PH_RDPAGE || q.phase == PH_RDLOCK;
  assign commit = q.busy && q.busyCnt == CNT_W'(1);
  // Acceptance at deselect; a partial byte cancels both
  assign startWrite = csRise && q.phase == PH_WDATA && q.gotData
    && q.bitCnt == 3'h0 && q.write_enable_latch && !lockedNv && !q.busy;
  assign startLock = csRise && q.phase == PH_LOCKDATA && q.gotData
    && q.bitCnt == 3'h0 && q.lockReq && q.write_enable_latch
    && {blockProtectHi, blockProtectLo} != BP_ALL
    && !lockedNv && !q.busy;

  // Producer: page bytes stop at the last slot, status byte repeats
  assign bufInValid = (q.phase == PH_RDPAGE && !q.rdDone)
    || q.phase == PH_RDLOCK;
  assign bufInData = q.phase == PH_RDLOCK ? {LOCK_STATUS_PAD, lockedNv}
    : corrPage[q.addr*8 +: 8];
  assign bufPush = bufInValid && bufInReady;
  assign bufOutReady = sckFall && readPhase && q.outCnt == 3'h0;
  // Prefetch buffer so the shifter never waits on a lookup
  byte_buffer2 #(.WIDTH(8)) outBuf (
    .clk(clk),
    .rst(rst),
    .clear(csRise),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .inData(bufInData),
    .outValid(bufOutValid),
    .outReady(bufOutReady),
    .outData(bufOutData)
  );

  // Next-state logic of the whole instruction engine
  always_comb begin
    d = q;
    d.csMeta = csN;
    d.csSync = q.csMeta;
    d.csPrev = q.csSync;
    d.sckMeta = sck;
    d.sckSync = q.sckMeta;
    d.sckPrev = q.sckSync;
    d.siMeta = si;
    d.siSync = q.siMeta;
    if (q.csSync) begin
      d.armed = 1'b1;
    end
    if (commit) begin
      d.busy = 1'b0;
      d.write_enable_latch = 1'b0;
    end else if (q.busy) begin
      d.busyCnt = q.busyCnt - CNT_W'(1);
    end
    if (csRise) begin
      if (q.phase == PH_WRITE_ENABLE_CMD && q.bitCnt == 3'h0) begin
        d.write_enable_latch = 1'b1;
      end
      if (startWrite || startLock) begin
        d.busy = 1'b1;
        d.kindLock = startLock;
        d.busyCnt = CNT_W'(WRITE_CYCLES);
      end
      d.phase = PH_IDLE;
      d.soEn = 1'b0;
      d.so = 1'b0;
    end else if (csFall && q.armed) begin
      d.phase = PH_OPCODE;
      d.bitCnt = 3'h0;
      d.gotData = 1'b0;
      d.lockReq = 1'b0;
      d.rdDone = 1'b0;
      d.outCnt = 3'h0;
    end else if (sckRise && q.phase != PH_IDLE) begin
      d.inShift = newByte;
      d.bitCnt = q.bitCnt + 3'h1;
      if (byteDone) begin
        case (q.phase)
          PH_OPCODE: begin
            if (q.busy) begin
              d.phase = PH_IGNORE;
            end else if ((newByte & OPCODE_MASK) == WRITE_ENABLE_CMD) begin
              d.phase = PH_WRITE_ENABLE_CMD;
            end else if ((newByte & OPCODE_MASK) == ID_PAGE_WRITE_CMD) begin
              d.phase = PH_ADDR_WR;
            end else if ((newByte & OPCODE_MASK) == ID_PAGE_READ_CMD) begin
              d.phase = PH_ADDR_RD;
            end else begin
              d.phase = PH_IGNORE;
            end
          end
          PH_ADDR_WR: begin
            d.addr = newByte[ADDR_W-1:0];
            d.stage = corrPage;
            d.dirty = '0;
            d.phase = newByte[ADDR_SELECT_BIT] ? PH_LOCKDATA : PH_WDATA;
          end
          PH_ADDR_RD: begin
            d.addr = newByte[ADDR_W-1:0];
            d.phase = newByte[ADDR_SELECT_BIT] ? PH_RDLOCK : PH_RDPAGE;
            d.soEn = 1'b1;
          end
          PH_WDATA: begin
            d.stage[q.addr*8 +: 8] = newByte;
            d.dirty[q.addr[ADDR_W-1:2]] = 1'b1;
            d.addr = q.addr + ADDR_W'(1);
            d.gotData = 1'b1;
          end
          PH_LOCKDATA: begin
            d.lockReq = newByte[LOCK_DATA_BIT];
            d.gotData = 1'b1;
          end
          PH_WRITE_ENABLE_CMD: begin
            d.phase = PH_IGNORE;
          end
          default: begin
          end
        endcase
      end
    end
    if (sckFall && readPhase && !csRise) begin
      if (q.outCnt == 3'h0) begin
        d.so = bufOutValid ? bufOutData[7] : ERASED_BYTE[7];
        d.outShift = bufOutValid ? {bufOutData[6:0], 1'b0} : ERASED_BYTE;
        d.outCnt = 3'h7;
      end else begin
        d.so = q.outShift[7];
        d.outShift = {q.outShift[6:0], 1'b0};
        d.outCnt = q.outCnt - 3'h1;
      end
    end
    if (bufPush && q.phase == PH_RDPAGE) begin
      if (q.addr == LAST_ADDR) begin
        d.rdDone = 1'b1;
      end else begin
        d.addr = q.addr + ADDR_W'(1);
      end
    end
  end
  // Reset leaves the chip idle, deselected and disarmed
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      {q.csMeta, q.csSync, q.csPrev} <= 3'h7;
    end else begin
      q <= d;
    end
  end
  // Whole groups are re-encoded so the check bits stay consistent
  always_ff @(posedge clk) begin
    if (commit && !q.kindLock) begin
      for (int g = 0; g < GROUPS; g++) begin
        if (q.dirty[g]) begin
          pageMem[g] <= eccEncode(q.stage[g*GROUP_W +: GROUP_W]);
        end
      end
    end
    if (commit && q.kindLock) begin
      lockedNv <= 1'b1;
    end
  end
  assign so = q.so;
  assign soEn = q.soEn;
  assign writeEnableLatch = q.write_enable_latch;
  assign writeBusy = q.busy;
  assign pageLocked = lockedNv;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_busy_ignores: assert property (
    (q.busy && byteDone && q.phase == PH_OPCODE) |=> q.phase == PH_IGNORE)
    else $error("instruction taken during write cycle");
  chk_deselect_ends: assert property (
    csRise |=> !soEn && q.phase == PH_IDLE)
    else $error("deselect did not end transfer");
  chk_wel_cleared: assert property (
    commit |=> !writeEnableLatch && !writeBusy)
    else $error("latch not cleared after write");
  chk_lock_permanent: assert property (
    !$fell(lockedNv))
    else $error("page lock was released");
  chk_lock_guard: assert property (
    ($rose(q.busy) && q.kindLock) |-> $past(q.write_enable_latch) && !$past(lockedNv)
      && !($past(blockProtectHi) && $past(blockProtectLo)))
    else $error("lock started without its conditions");
  chk_write_guard: assert property (
    ($rose(q.busy) && !q.kindLock) |-> !$past(lockedNv) && $past(q.write_enable_latch))
    else $error("page write started while refused");
  chk_cycle_count: assert property (
    (q.busy && q.busyCnt > CNT_W'(1)) |=> q.busy
      && q.busyCnt == $past(q.busyCnt) - CNT_W'(1))
    else $error("write cycle timer misbehaved");
  chk_status_byte: assert property (
    (bufPush && q.phase == PH_RDLOCK) |-> bufInData == {7'h00, pageLocked})
    else $error("lock status byte wrong");
  chk_no_wrap: assert property (
    (bufPush && q.phase == PH_RDPAGE && q.addr == LAST_ADDR)
      |=> q.addr == LAST_ADDR && !bufInValid)
    else $error("page read wrapped");
  chk_ecc_single: assert property (
    eccCorrect(pageMem[0] ^ (CODE_W'(1) << q.bitCnt)) == corrPage[GROUP_W-1:0])
    else $error("single bit error not corrected");
  cov_page_write: cover property ($rose(q.busy) && !q.kindLock);
  cov_page_lock: cover property ($rose(q.busy) && q.kindLock);
  cov_page_read: cover property (bufOutReady && q.phase == PH_RDPAGE);
  cov_status_read: cover property (bufOutReady && q.phase == PH_RDLOCK);
endmodule : id_page_access

// File: bench/spi_host_model.sv
module spi_host_model (
  // Clock
  input wire logic clk,
  // Link pins driven toward the device
  output logic csN,
  output logic sck,
  output logic si,
  // Link pin driven by the device
  input wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle link: deselected, clock parked low as mode 0 expects
  initial begin
    csN = 1'h1;
    sck = 1'h0;
    si = 1'h0;
  end

  // Select, then leave setup time before the first clock rise
  task automatic sel();
    @(posedge clk) csN <= 1'h0;
    repeat (4) @(posedge clk);
  endtask : sel

  // Deselect while the clock is low, before any further rise
  task automatic desel();
    repeat (2) @(posedge clk);
    csN <= 1'h1;
    si <= ~si; // Released line keeps moving so no stale level passes
    repeat (6) @(posedge clk);
  endtask : desel

  // Shift bits MSB first, 4 clk low and 4 clk high per bit; read data
  // is taken mid high phase, well after the device has settled it
  task automatic xfer(input logic [7:0] tx, input int nBits,
                      output logic [7:0] rx);
    rx = 8'hff;
    for (int i = 7; i > 7 - nBits; i--) begin
      @(posedge clk) begin
        sck <= 1'h0;
        si <= tx[i];
      end
      repeat (3) @(posedge clk);
      @(posedge clk) sck <= 1'h1;
      repeat (2) @(posedge clk);
      @(negedge clk) rx[i] = so;
      @(posedge clk);
    end
    @(posedge clk) sck <= 1'h0;
  endtask : xfer
endmodule : spi_host_model

// File: bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import id_page_pkg::*;

  // Short write cycle keeps the run brief but outlasts two read frames
  localparam int WCYC = 800;

  typedef struct packed {
    logic [7:0] op, a, e0, e1;
  } row_t;

  logic clk = 1'h0;
  logic rst = 1'h1;
  logic bpHi = 1'h0;
  logic bpLo = 1'h0;
  logic csN, sck, si, so, soEn, write_enable_latch, busy, locked;
  logic enSeen = 1'h0;
  logic [7:0] r0, r1, rx;
  int badCount = 0;
  int comparisons = 0;

  // Read frames checked right after the first page write
  row_t rows [5] = '{
    '{8'h83, 8'h0e, 8'hff, 8'ha5},
    '{8'h8b, 8'h7f, 8'ha5, 8'hff},
    '{8'h83, 8'h00, 8'h5a, 8'hff},
    '{8'h83, 8'h05, 8'hff, 8'hff},
    '{8'h83, 8'h80, 8'h00, 8'h00}
  };

  // Core clock, 100 MHz
  always #5 clk = ~clk;

  // Remember whether the output driver was ever enabled in a frame
  always @(posedge clk) if (soEn === 1'h1) enSeen <= 1'h1;

  id_page_access #(.WRITE_CYCLES(WCYC)) uut (
    .clk(clk), .rst(rst), .csN(csN), .sck(sck), .si(si), .so(so),
    .soEn(soEn), .blockProtectHi(bpHi), .blockProtectLo(bpLo),
    .writeEnableLatch(write_enable_latch), .writeBusy(busy), .pageLocked(locked)
  );

  spi_host_model host (.clk(clk), .csN(csN), .sck(sck), .si(si), .so(so));

  // Status flags packed for a single compare
  function automatic logic [7:0] st();
    return {4'h0, soEn, write_enable_latch, busy, locked};
  endfunction : st

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One frame of n whole bytes, first byte in the top of b
  task automatic send(input logic [31:0] b, input int n);
    host.sel();
    for (int k = 0; k < n; k++) begin
      host.xfer(b[31-8*k -: 8], 8, rx);
    end
    host.desel();
    @(negedge clk);
  endtask : send

  // Read frame returning two data bytes
  task automatic rd(input logic [7:0] op, input logic [7:0] a);
    enSeen = 1'h0;
    host.sel();
    host.xfer(op, 8, rx);
    host.xfer(a, 8, rx);
    host.xfer(8'hff, 8, r0);
    host.xfer(8'hff, 8, r1);
    host.desel();
    @(negedge clk);
  endtask : rd

  // Bounded wait for the write cycle to finish
  task automatic idle();
    int c;
    c = 0;
    while (busy !== 1'h0 && c < WCYC + 50) begin
      @(negedge clk);
      c++;
    end
    check({7'h0, busy}, 8'h00);
  endtask : idle

  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : completeRun

  // Watchdog: the sequence needs well under a fifth of this
  initial begin
    repeat (60000) @(posedge clk);
    badCount++;
    completeRun();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    repeat (6) @(negedge clk);
    check(st(), 8'h00);
    send({WRITE_ENABLE_CMD, 24'h0}, 1);
    check(st(), 8'h04);
    // Slot 15 then wrap to slot 0, groups 3 and 0; opcode bit 3 set
    send({8'h8a, 8'h7f, 8'ha5, 8'h5a}, 4);
    check({7'h0, busy}, 8'h01);
    repeat (WCYC - 20) @(negedge clk);
    check({7'h0, busy}, 8'h01);
    idle();
    check(st(), 8'h00);
    foreach (rows[i]) begin
      rd(rows[i].op, rows[i].a);
      check(r0, rows[i].e0);
      check(r1, rows[i].e1);
      check({7'h0, enSeen}, 8'h01);
    end
    // Reading on from the last slot must not wrap to slot 0
    rd(ID_PAGE_READ_CMD, 8'h0f);
    check(r1, ERASED_BYTE);
    // Page write without the latch leaves the page untouched
    send({ID_PAGE_WRITE_CMD, 24'h010000}, 4);
    check(st(), 8'h00);
    rd(ID_PAGE_READ_CMD, 8'h01);
    check(r0, ERASED_BYTE);
    // Lock refused: no latch, then both protect bits, then bad data
    send({ID_PAGE_WRITE_CMD, 24'h800200}, 3);
    check(st(), 8'h00);
    @(posedge clk) {bpHi, bpLo} <= 2'h3;
    send({WRITE_ENABLE_CMD, 24'h0}, 1);
    send({ID_PAGE_WRITE_CMD, 24'h800200}, 3);
    check(st(), 8'h04);
    @(posedge clk) {bpHi, bpLo} <= 2'h2;
    send({ID_PAGE_WRITE_CMD, 24'h80fd00}, 3);
    check(st(), 8'h04);
    // Deselect three bits into a second data byte
    host.sel();
    host.xfer(ID_PAGE_WRITE_CMD, 8, rx);
    host.xfer(8'h80, 8, rx);
    host.xfer(8'h02, 8, rx);
    host.xfer(8'hff, 3, rx);
    host.desel();
    @(negedge clk);
    check(st(), 8'h04);
    // Accepted lock; reads during the cycle must stay silent
    send({ID_PAGE_WRITE_CMD, 24'hff0200}, 3);
    check(st(), 8'h06);
    rd(ID_PAGE_READ_CMD, 8'h00);
    check({7'h0, enSeen}, 8'h00);
    rd(ID_PAGE_READ_CMD, 8'h80);
    check({7'h0, enSeen}, 8'h00);
    idle();
    check(st(), 8'h01);
    rd(ID_PAGE_READ_CMD, 8'h80);
    check(r0, 8'h01);
    check(r1, 8'h01);
    // Locked page refuses both writing and locking again
    send({WRITE_ENABLE_CMD, 24'h0}, 1);
    send({ID_PAGE_WRITE_CMD, 24'h000000}, 3);
    check(st(), 8'h05);
    send({ID_PAGE_WRITE_CMD, 24'h800200}, 3);
    check(st(), 8'h05);
    rd(ID_PAGE_READ_CMD, 8'h00);
    check(r0, 8'h5a);
    // Read cut off mid byte releases the output
    host.sel();
    host.xfer(ID_PAGE_READ_CMD, 8, rx);
    host.xfer(8'h04, 8, rx);
    host.xfer(8'hff, 4, rx);
    host.desel();
    @(negedge clk);
    check(st(), 8'h05);
    // Reset in mid run clears the latch, keeps the lock
    @(posedge clk) rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    repeat (6) @(negedge clk);
    check(st(), 8'h01);
    completeRun();
  end
endmodule : testbench
